//--- sacq_assertions.sv
// port-level assertion checker for the segmented acquisition sequencer
`timescale 1ns/100ps
module sacq_checker
  import sacq_pkg::*;
(
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  input wire logic [3:0]                addr_in,
  input wire logic [31:0]               wdata_in,
  input wire logic                      wr_in,
  input wire logic                      rd_in,
  input wire logic [31:0]               rdata_out,
  input wire logic                      sample_valid_in,
  input wire logic                      mem_we_out,
  input wire logic [sacq_pkg::ADDR_W-1:0] mem_addr_out,
  input wire logic                      show_valid_out,
  input wire logic                      acq_busy_out,
  input wire logic                      irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property ($past(rd_in) && $past(addr_in) > REG_STAMP
    |-> rdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  store_cause_a: assert property (mem_we_out |-> $past(sample_valid_in) && $past(acq_busy_out))
    else $error("memory write without a sample while acquiring");
  addr_step_a: assert property (mem_we_out && $past(mem_we_out)
    |-> mem_addr_out == $past(mem_addr_out) + 24'h00_0001 || mem_addr_out == 24'h00_0000)
    else $error("memory address did not step by one");
  show_idle_a: assert property (show_valid_out |-> !$past(acq_busy_out))
    else $error("segment shown while acquiring");
  stop_cancel_a: assert property (wr_in && addr_in == REG_CMD && wdata_in[CMD_STOP]
    |-> ##1 !acq_busy_out) else $error("stop did not end acquisition");
  arm_start_a: assert property (wr_in && addr_in == REG_CMD && wdata_in[1:0] == 2'b01
    |-> ##1 acq_busy_out) else $error("arm did not start acquisition");
  irq_clear_a: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("interrupt dropped without a register write");
endmodule // sacq_checker

bind sacq_top sacq_checker i_chk (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .sample_valid_in, .mem_we_out, .mem_addr_out, .show_valid_out, .acq_busy_out,
  .irq_out);

//--- sacq_pkg.sv
// constants and types for the segmented acquisition sequencer
// Summary of operation
// [RL1] sequence setting: off, on for a bounded number of segments, or wrap
// [RL2] host picks segment count; each pass fills exactly that many segments
// [RL3] maximum record length in samples limits each segment's stored samples
// [RL4] single mode: one segment per trigger until count reached, then halt
// [RL5] host may stop a partly filled sequence; device aborts it
// [RL6] normal mode: all segments filled, data handed on, restart at segment one
// [RL7] auto mode: trigger gap beyond time-out restarts at segment one
// [RL8] wrap: fill forever, overwriting oldest segment, until stopped
// [RL9] wrap stopped: present last n segments, oldest first, for display
// [RL10] wrap with auto: trigger gap beyond time-out stops acquisition
// [RL11] auto, normal and single trigger modes, each directly selectable
// [RL12] stop command cancels acquisition at any moment, in any state; code ignores stop in idle and halt
// [RL13] external sample clock disables time stamps, auto time-out, dead time; code has no dead time
// [RL14] time-out counter restarts per trigger, expires only without trigger
package sacq_pkg;
  localparam int SEG_W     = 10;
  localparam int LEN_W     = 16;
  localparam int TO_W      = 32;
  localparam int STAMP_W   = 32;
  localparam int ADDR_W    = 24;

  localparam logic [SEG_W-1:0]  SEG_ONE   = 10'h001;
  localparam logic [SEG_W-1:0]  SEG_ZERO  = 10'h000;
  localparam logic [LEN_W-1:0]  LEN_ONE   = 16'h0001;
  localparam logic [LEN_W-1:0]  LEN_ZERO  = 16'h0000;
  localparam logic [TO_W-1:0]   TO_ONE    = 32'h0000_0001;
  localparam logic [TO_W-1:0]   TO_ZERO   = 32'h0000_0000;
  localparam logic [STAMP_W-1:0] STAMP_ONE = 32'h0000_0001;

  // register offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_SEGS    = 4'h1;
  localparam logic [3:0] REG_MAXLEN  = 4'h2;
  localparam logic [3:0] REG_TIMEOUT = 4'h3;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_IRQ     = 4'h5;
  localparam logic [3:0] REG_MASK    = 4'h6;
  localparam logic [3:0] REG_CMD     = 4'h7;
  localparam logic [3:0] REG_STAMP   = 4'h8;

  // ctrl fields
  localparam int CTRL_SEQ_LSB  = 0;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_EXTCLK   = 4;
  // cmd fields
  localparam int CMD_ARM  = 0;
  localparam int CMD_STOP = 1;
  // irq fields
  localparam int IRQ_SEG   = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_TOUT  = 2;
  localparam int IRQ_ABORT = 3;
  localparam int IRQ_W     = 4;

  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [SEG_W-1:0] SEGS_RESET = 10'h001;
  localparam logic [LEN_W-1:0] LEN_RESET  = 16'h0100;
  localparam logic [TO_W-1:0]  TO_RESET   = 32'h0000_1000;

  typedef enum logic [1:0] {
    SACQ_SEQ_OFF  = 2'b00,
    SACQ_SEQ_ON   = 2'b01,
    SACQ_SEQ_WRAP = 2'b10
  } sacq_seq_t;

  typedef enum logic [1:0] {
    SACQ_TRIG_AUTO   = 2'b00,
    SACQ_TRIG_NORMAL = 2'b01,
    SACQ_TRIG_SINGLE = 2'b10
  } sacq_trig_t;

  typedef enum logic [2:0] {
    SACQ_IDLE    = 3'b000,
    SACQ_WAIT    = 3'b001,
    SACQ_FILL    = 3'b010,
    SACQ_PRESENT = 3'b011,
    SACQ_HALT    = 3'b100
  } sacq_state_t;
endpackage

//--- sacq_tb_top.sv
// self-checking testbench for the segmented acquisition sequencer
`timescale 1ns/100ps
module sacq_tb_top;
  import sacq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, start = 1'b0, slow = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, r;
  logic [7:0] ntrig = 8'h00, nsamp = 8'h00;
  logic [15:0] gap = 16'h0000;
  logic trig, samp, we, shv, busy, irq, done;
  logic [ADDR_W-1:0] maddr, last_addr;
  logic [SEG_W-1:0] shs, first_seg;
  int bad_count = 0, tests_run = 0, we_cnt = 0, show_cnt = 0, cyc = 0, n, l;
  always #2 clk = ~clk;
  sacq_top i_dut (.clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .trig_in(trig), .sample_valid_in(samp), .mem_we_out(we),
    .mem_addr_out(maddr), .show_valid_out(shv), .show_seg_out(shs), .acq_busy_out(busy),
    .irq_out(irq));
  sacq_trig_model i_far (.clk_in(clk), .start_in(start), .slow_in(slow), .ntrig_in(ntrig),
    .gap_in(gap), .nsamp_in(nsamp), .trig_out(trig), .sample_out(samp), .done_out(done));
  task give_verdict(input int extra);
    bad_count += extra;
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (we === 1'b1) last_addr = maddr;
    we_cnt += (we === 1'b1);
    if (shv === 1'b1 && show_cnt == 0) first_seg = shs;
    show_cnt += (shv === 1'b1);
    if (cyc == 40000) give_verdict(1);
  end
  function automatic logic [31:0] fill_total(input int segs, input int len);
    return 32'(segs * len);
  endfunction
  function automatic logic [31:0] wrap_first(input int total, input int segs);
    return 32'(total % segs);
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", nm, e, g);
    bad_count += (g !== e);
  endtask
  // one strobe per call; the idle cycle after keeps each strobe a single assignment
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rchk(input string nm, input logic [3:0] a, input logic [31:0] e,
            input logic [31:0] m = 32'hffff_ffff);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
    @(posedge clk);
    chk(nm, e, r & m);
  endtask
  task arm(input logic [31:0] c, input int segs);
    wr_reg(REG_CMD, 32'h0000_0002);
    wr_reg(REG_CTRL, c);
    wr_reg(REG_SEGS, segs);
    wr_reg(REG_MAXLEN, l);
    wr_reg(REG_IRQ, 32'h0000_000f);
    wr_reg(REG_CMD, 32'h0000_0001);
    we_cnt = 0;
    show_cnt = 0;
  endtask
  task burst(input int nt, input int gp);
    ntrig <= 8'(nt);
    gap <= 16'(gp);
    nsamp <= 8'(l);
    slow <= ($urandom % 2) == 1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5000 && done !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    r = $urandom(32'h6a03b867);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("segs", REG_SEGS, 32'h0000_0001);
    rchk("maxlen", REG_MAXLEN, 32'h0000_0100);
    rchk("timeout", REG_TIMEOUT, 32'h0000_1000);
    rchk("ctrl", REG_CTRL, 32'h0000_0000);
    rchk("unmapped", 4'hf, 32'h0000_0000);
    wr_reg(REG_SEGS, 32'h0000_0000);
    rchk("segs floor", REG_SEGS, 32'h0000_0001);
    wr_reg(REG_MASK, 32'h0000_000f);
    n = 2 + $urandom % 3;
    l = 2 + $urandom % 6;
    arm(32'h0000_0009, n);
    burst(n, 2);
    burst(1, 2);
    chk("single samples", fill_total(n, l), we_cnt);
    chk("single last", fill_total(n, l) - 1, last_addr);
    chk("single busy", 0, busy);
    rchk("single irq", REG_IRQ, 32'h0000_0003);
    chk("irq level", 1, irq);
    wr_reg(REG_IRQ, 32'h0000_000f);
    chk("irq clear", 0, irq);
    arm(32'h0000_0008, n);
    burst(2, 2);
    chk("off samples", l, we_cnt);
    arm(32'h0000_0005, n);
    burst(n, 2);
    repeat (n + 8) @(posedge clk);
    chk("shown", n, show_cnt);
    chk("rewait", 1, busy);
    burst(1, 2);
    chk("restart addr", l - 1, last_addr);
    wr_reg(REG_CMD, 32'h0000_0002);
    chk("stopped", 0, busy);
    rchk("abort irq", REG_IRQ, 32'h0000_0008, 32'h0000_0008);
    arm(32'h0000_0006, 2);
    burst(5, 2);
    chk("wrap samples", fill_total(5, l), we_cnt);
    chk("wrap last", l - 1, last_addr);
    wr_reg(REG_CMD, 32'h0000_0002);
    repeat (8) @(posedge clk);
    chk("wrap shown", 2, show_cnt);
    chk("wrap oldest", wrap_first(5, 2), first_seg);
    wr_reg(REG_TIMEOUT, 32'h0000_0020);
    arm(32'h0000_0001, 3);
    burst(1, 0);
    burst(1, 40);
    chk("auto restart", l - 1, last_addr);
    rchk("tout irq", REG_IRQ, 32'h0000_0004, 32'h0000_0004);
    arm(32'h0000_0001, 3);
    burst(3, 5);
    chk("gap kept", fill_total(3, l) - 1, last_addr);
    arm(32'h0000_0011, 3);
    burst(1, 0);
    burst(1, 40);
    chk("ext clock", fill_total(2, l) - 1, last_addr);
    rchk("ext stamp", REG_STAMP, 32'h0000_0000);
    arm(32'h0000_0002, 2);
    burst(2, 0);
    repeat (40) @(posedge clk);
    chk("wrap auto stop", 0, busy);
    chk("wrap auto shown", 2, show_cnt);
    rchk("wrap status", REG_STATUS, 32'h0000_9000);
    give_verdict(0);
  end
endmodule // sacq_tb_top

//--- sacq_top.sv
// segmented acquisition sequencer: trigger-driven fill of memory segments
`timescale 1ns/100ps
module sacq_top
(
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [3:0]                    addr_in,
  input  wire logic [31:0]                   wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  output logic [31:0]                        rdata_out,
  input  wire logic                          trig_in,
  input  wire logic                          sample_valid_in,
  output logic                               mem_we_out,
  output logic [sacq_pkg::ADDR_W-1:0]        mem_addr_out,
  output logic                               show_valid_out,
  output logic [sacq_pkg::SEG_W-1:0]         show_seg_out,
  output logic                               acq_busy_out,
  output logic                               irq_out
);
  import sacq_pkg::*;

  typedef struct packed {
    logic [1:0]         seq;
    logic [1:0]         trig;
    logic               extclk;
    logic [SEG_W-1:0]   segs;
    logic [LEN_W-1:0]   maxlen;
    logic [TO_W-1:0]    tout;
    logic [IRQ_W-1:0]   irq;
    logic [IRQ_W-1:0]   mask;
    sacq_state_t        state;
    logic [SEG_W-1:0]   seg;
    logic [LEN_W-1:0]   cnt;
    logic [TO_W-1:0]    gap;
    logic               gap_run;
    logic               wrapped;
    logic [SEG_W-1:0]   shown;
    logic [STAMP_W-1:0] now;
    logic [STAMP_W-1:0] stamp;
    logic [31:0]        rdata;
    logic               mem_we;
    logic [ADDR_W-1:0]  mem_addr;
    logic               show_valid;
    logic [SEG_W-1:0]   show_seg;
    logic               busy;
    logic               irq_o;
  } sacq_regs_t;

  sacq_regs_t r;
  sacq_regs_t next_r;

  function automatic logic [SEG_W-1:0] seg_inc(input logic [SEG_W-1:0] s,
                                               input logic [SEG_W-1:0] n);
    seg_inc = (s + SEG_ONE >= n) ? SEG_ZERO : s + SEG_ONE;
  endfunction

  function automatic logic [ADDR_W-1:0] seg_addr(input logic [SEG_W-1:0] s,
                                                 input logic [LEN_W-1:0] len,
                                                 input logic [LEN_W-1:0] c);
    logic [ADDR_W-1:0] base;
    // widen before the product so a large segment base does not fold back
    base     = ADDR_W'(s) * ADDR_W'(len);
    seg_addr = base + ADDR_W'(c);
  endfunction

  // segments per pass; sequence off behaves as a single segment
  function automatic logic [SEG_W-1:0] pass_len(input logic [1:0]       seq,
                                                input logic [SEG_W-1:0] segs);
    pass_len = (seq == SACQ_SEQ_OFF) ? SEG_ONE : segs;
  endfunction

  // ring slot of the k-th shown segment; a spare bit keeps the sum from wrapping
  function automatic logic [SEG_W-1:0] ring_slot(input logic [SEG_W-1:0] start,
                                                 input logic [SEG_W-1:0] k,
                                                 input logic [SEG_W-1:0] n);
    logic [SEG_W:0] sum;
    sum       = {1'b0, start} + {1'b0, k};
    ring_slot = (sum >= {1'b0, n}) ? SEG_W'(sum - {1'b0, n}) : sum[SEG_W-1:0];
  endfunction

  // one bit of a write to the command register, used as a strobe
  function automatic logic cmd_bit(input logic        wr,
                                   input logic [3:0]  a,
                                   input logic [31:0] d,
                                   input int          b);
    cmd_bit = wr && a == REG_CMD && d[b];
  endfunction

  logic wr_cmd_stop;
  logic wr_cmd_arm;
  logic tout_hit;
  logic seq_on;
  logic wrap_mode;
  logic last_seg;

  always_comb
  begin
    wr_cmd_stop = cmd_bit(wr_in, addr_in, wdata_in, CMD_STOP);
    wr_cmd_arm  = cmd_bit(wr_in, addr_in, wdata_in, CMD_ARM);
    seq_on      = r.seq != SACQ_SEQ_OFF;
    wrap_mode   = r.seq == SACQ_SEQ_WRAP;
    // segment being filled is the last one of the pass
    last_seg    = r.seg + SEG_ONE >= r.segs || !seq_on;
    // no time-out on an external sample clock
    // a trigger in the expiry cycle wins, so the gap restarts instead
    tout_hit    = r.gap_run && !r.extclk && r.trig == SACQ_TRIG_AUTO && // RL13
                  r.gap >= r.tout && !trig_in; // RL14
  end

  always_comb
  begin
    next_r            = r;
    next_r.mem_we     = 1'b0;
    next_r.show_valid = 1'b0;
    next_r.rdata      = 32'h0000_0000;
    next_r.now        = r.now + STAMP_ONE;

    // register writes
    if (wr_in)
    begin
      unique case (addr_in)
        REG_CTRL:
        begin
          next_r.seq    = wdata_in[CTRL_SEQ_LSB +: 2]; // RL1
          next_r.trig   = wdata_in[CTRL_TRIG_LSB +: 2]; // RL11
          next_r.extclk = wdata_in[CTRL_EXTCLK];
        end
        REG_SEGS:
        begin
          // a count of zero would end every pass after one segment; floor it at one
          if (wdata_in[SEG_W-1:0] == SEG_ZERO)
            next_r.segs = SEG_ONE;
          else
            next_r.segs = wdata_in[SEG_W-1:0]; // RL2
        end
        REG_MAXLEN:
        begin
          if (wdata_in[LEN_W-1:0] == LEN_ZERO)
            next_r.maxlen = LEN_ONE;
          else
            next_r.maxlen = wdata_in[LEN_W-1:0]; // RL3
        end
        REG_TIMEOUT:
        begin
          // counted in clock cycles from the last accepted trigger
          next_r.tout = wdata_in;
        end
        REG_IRQ:
        begin
          // write one to clear; an event in the same cycle sets it again below
          next_r.irq = r.irq & ~wdata_in[IRQ_W-1:0];
        end
        REG_MASK:
        begin
          next_r.mask = wdata_in[IRQ_W-1:0];
        end
        // status, stamp and command hold nothing writable
        default:     ;
      endcase
    end
    if (rd_in)
    begin
      unique case (addr_in)
        REG_CTRL:    next_r.rdata = {27'h000_0000, r.extclk, r.trig, r.seq};
        REG_SEGS:    next_r.rdata = {22'h00_0000, r.segs};
        REG_MAXLEN:  next_r.rdata = {16'h0000, r.maxlen};
        REG_TIMEOUT: next_r.rdata = r.tout;
        // wrapped flag, state and current segment
        REG_STATUS:  next_r.rdata = {16'h0000, r.wrapped, 2'b00, r.state, r.seg};
        REG_IRQ:     next_r.rdata = {28'h000_0000, r.irq};
        REG_MASK:    next_r.rdata = {28'h000_0000, r.mask};
        REG_STAMP:   next_r.rdata = r.extclk ? 32'h0000_0000 : r.stamp; // RL13
        default:     next_r.rdata = 32'h0000_0000;
      endcase
    end

    // gap counter runs only between triggers
    // and saturates, so a long silence still reads as expired
    if (r.gap_run && r.gap != {TO_W{1'b1}})
      next_r.gap = r.gap + TO_ONE;

    unique case (r.state)
      // arming starts a fresh pass with the gap counter idle
      SACQ_IDLE, SACQ_HALT:
        if (wr_cmd_arm)
        begin
          next_r.state   = SACQ_WAIT;
          next_r.seg     = SEG_ZERO;
          next_r.wrapped = 1'b0;
          next_r.gap_run = 1'b0;
        end
      SACQ_WAIT:
        if (tout_hit)
        begin
          next_r.gap_run = 1'b0;
          next_r.irq[IRQ_TOUT] = 1'b1;
          if (r.seq == SACQ_SEQ_WRAP)
          begin
            next_r.state = SACQ_PRESENT; // RL10
            next_r.shown = SEG_ZERO;
          end
          else
            next_r.seg = SEG_ZERO; // RL7
        end
        else if (trig_in)
        begin
          next_r.state   = SACQ_FILL;
          next_r.cnt     = LEN_ZERO;
          next_r.gap     = TO_ZERO; // RL14
          next_r.gap_run = 1'b1;
          next_r.stamp   = r.now;
        end
      SACQ_FILL:
        if (sample_valid_in)
        begin
          next_r.mem_we   = 1'b1;
          next_r.mem_addr = seg_addr(r.seg, r.maxlen, r.cnt);
          next_r.cnt      = r.cnt + LEN_ONE;
          // last sample of this segment
          if (r.cnt + LEN_ONE >= r.maxlen) // RL3
          begin
            next_r.irq[IRQ_SEG] = 1'b1;
            next_r.seg = seg_inc(r.seg, pass_len(r.seq, r.segs)); // RL2
            next_r.state = SACQ_WAIT;
            if (wrap_mode)
            begin
              // oldest segment overwritten next
              if (last_seg) // RL8
                next_r.wrapped = 1'b1;
            end
            else if (last_seg)
            begin
              next_r.irq[IRQ_DONE] = 1'b1;
              next_r.shown = SEG_ZERO;
              if (r.trig == SACQ_TRIG_SINGLE)
                next_r.state = SACQ_HALT; // RL4
              else
                next_r.state = SACQ_PRESENT; // RL6
            end
          end
        end
      SACQ_PRESENT:
      begin
        // walks segments oldest first; start is the write slot once wrapped
        next_r.show_valid = 1'b1;
        next_r.show_seg   = (wrap_mode && r.wrapped) ?
                            ring_slot(r.seg, r.shown, r.segs) : r.shown; // RL9
        next_r.shown      = r.shown + SEG_ONE;
        if (r.shown + SEG_ONE >= ((wrap_mode && !r.wrapped) ? r.seg
                                  : pass_len(r.seq, r.segs)))
        begin
          if (wrap_mode || r.trig == SACQ_TRIG_SINGLE)
            next_r.state = SACQ_HALT;
          else
          begin
            next_r.state   = SACQ_WAIT; // RL6
            next_r.seg     = SEG_ZERO;
            next_r.gap_run = 1'b0;
          end
        end
      end
      default: next_r.state = SACQ_IDLE;
    endcase

    // stop overrides the next state, write strobe and gap counter, but only outside idle and halt
    if (wr_cmd_stop && r.state != SACQ_IDLE && r.state != SACQ_HALT) // RL12
    begin
      next_r.mem_we  = 1'b0;
      next_r.gap_run = 1'b0;
      if (r.seq == SACQ_SEQ_WRAP && (r.wrapped || r.seg != SEG_ZERO))
      begin
        next_r.state = SACQ_PRESENT; // RL8
        next_r.shown = SEG_ZERO;
      end
      else
      begin
        next_r.state = SACQ_HALT; // RL5
        next_r.irq[IRQ_ABORT] = 1'b1;
      end
    end

    // taken from the state being entered so busy lines up with it
    next_r.busy  = next_r.state == SACQ_WAIT || next_r.state == SACQ_FILL;
    // level interrupt: sticky status under the mask
    next_r.irq_o = |(next_r.irq & next_r.mask);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      // clear all, then load the power-up settings
      r        <= '0;
      r.seq    <= CTRL_RESET[1:0];
      r.trig   <= CTRL_RESET[3:2];
      r.segs   <= SEGS_RESET;
      r.maxlen <= LEN_RESET;
      r.tout   <= TO_RESET;
      r.state  <= SACQ_IDLE;
    end
    else
      r <= next_r;
  end

  assign rdata_out      = r.rdata;
  assign mem_we_out     = r.mem_we;
  assign mem_addr_out   = r.mem_addr;
  assign show_valid_out = r.show_valid;
  assign show_seg_out   = r.show_seg;
  assign acq_busy_out   = r.busy;
  assign irq_out        = r.irq_o;
endmodule // sacq_top

//--- sacq_trig_model.sv
// trigger detector and sample stream model on the far side of the sequencer
`timescale 1ns/100ps
module sacq_trig_model
(
  input  wire logic        clk_in,
  input  wire logic        start_in,
  input  wire logic        slow_in,
  input  wire logic [7:0]  ntrig_in,
  input  wire logic [15:0] gap_in,
  input  wire logic [7:0]  nsamp_in,
  output logic             trig_out,
  output logic             sample_out,
  output logic             done_out
);
  initial {trig_out, sample_out, done_out} = 3'b001;
  always @(posedge clk_in)
  begin
    if (start_in)
    begin
      done_out <= 1'b0;
      repeat (ntrig_in)
      begin
        repeat (gap_in) @(posedge clk_in);
        trig_out <= 1'b1;
        @(posedge clk_in);
        trig_out <= 1'b0;
        repeat (nsamp_in)
        begin
          sample_out <= 1'b1;
          @(posedge clk_in);
          // slow stream drops the strobe between samples
          if (slow_in) sample_out <= 1'b0;
          if (slow_in) @(posedge clk_in);
        end
        sample_out <= 1'b0;
      end
      done_out <= 1'b1;
    end
  end
endmodule // sacq_trig_model
